// *** rtl/twf_pkg.sv ***
package twf_pkg;
    // sync word layout: [15:8] constant byte, [7:6] frame index, [5:4] ratio, [3] boost, [2:1] gain, [0] zero
    localparam logic [7:0] SYNC_CONST = 8'ha5;
    localparam int SYNC_IDX_POS = 6;
    localparam int SYNC_RATIO_POS = 4;
    localparam int SYNC_BOOST_POS = 3;
    localparam int SYNC_GAIN_POS = 1;
    // field widths
    localparam int SYNC_BITS = 16;
    localparam int CRC_BITS = 16;
    localparam int RES_SHORT_BITS = 16;
    localparam int RES_LONG_BITS = 24;
    localparam int FRAME_SHORT_BITS = 48;
    localparam int FRAME_LONG_BITS = 56;
    localparam int FRAMES_PER_SET = 4;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    // oversampling ratios
    localparam logic [9:0] OSR_64 = 10'h040;
    localparam logic [9:0] OSR_128 = 10'h080;
    localparam logic [9:0] OSR_256 = 10'h100;
    localparam logic [9:0] OSR_512 = 10'h200;
    // channel gains
    localparam logic [5:0] GAIN_1 = 6'h01;
    localparam logic [5:0] GAIN_8 = 6'h08;
    localparam logic [5:0] GAIN_16 = 6'h10;
    localparam logic [5:0] GAIN_32 = 6'h20;
    // bias: 0 means half current, 1 means full
    localparam logic BIAS_HALF = 1'b0;
    localparam logic BIAS_FULL = 1'b1;
    // watchdog timing, in nanoseconds and clock cycles at 100 ns
    localparam int CLK_PERIOD_NS = 100;
    localparam int WATCH_TIMEOUT_NS = 3600;
    localparam int WATCH_CYCLES = (WATCH_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // settling: number of results dropped before the first set
    localparam int SETTLE_RESULTS = 3;
    typedef enum logic [1:0] {
        TWF_IDLE = 2'b00,
        TWF_SEND = 2'b01,
        TWF_GAP = 2'b11
    } twf_state_type;
endpackage

// *** rtl/twf_watchdog.sv ***
`timescale 1ns/1ps
// measures how long the serial clock stays high, in main-clock cycles
module twf_watchdog
    import twf_pkg::*;
#(
    parameter int TIMEOUT = twf_pkg::WATCH_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic enable,
    input wire logic sck_level,
    output logic expired
);
    logic [15:0] count_q;
    logic expired_q;

    // count while high, clear on low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q <= 16'h0000;
        end else if (!enable || !sck_level) begin
            count_q <= 16'h0000;
        end else if (count_q != 16'hffff) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // one pulse at the timeout
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            expired_q <= 1'b0;
        end else begin
            expired_q <= enable && sck_level && (count_q == 16'(TIMEOUT - 1));
        end
    end
    assign expired = expired_q;

    AST_LOW_NO_RESET: assert property (@(posedge clk) disable iff (!resetn)
        !sck_level |=> !expired) else $error("watchdog fired with clock low");
endmodule

// *** rtl/twf_framer.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module twf_framer
    import twf_pkg::*;
#(
    parameter int WATCH_TIMEOUT = twf_pkg::WATCH_CYCLES,
    parameter int SETTLE = twf_pkg::SETTLE_RESULTS
) (
    input wire logic CLK,
    input wire logic RESETN,
    input wire logic SCK,
    input wire logic INTERFACE_SELECT_PIN,
    input wire logic DECIM_RATIO_BIT0,
    input wire logic DECIM_RATIO_BIT1,
    input wire logic CURRENT_BOOST_STRAP,
    input wire logic PGA_AMP_SEL_BIT0,
    input wire logic PGA_AMP_SEL_BIT1,
    input wire logic [23:0] CONVERSION_RESULT_WORD,
    input wire logic RESULT_VALID,
    output logic SDO,
    output logic SDO_OE,
    output logic TWO_WIRE_MODE,
    output logic [9:0] OSR_SETTING,
    output logic BIAS_SETTING,
    output logic [5:0] CH0_GAIN_SETTING,
    output logic PART_RESET_N
);
    import twf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers into CLK
    logic [6:0] pin_meta_q;
    logic [6:0] pin_sync_q;
    logic sel_prev_q;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_meta_q <= 7'h00;
            pin_sync_q <= 7'h00;
        end else begin
            pin_meta_q <= {SCK, INTERFACE_SELECT_PIN, DECIM_RATIO_BIT1, DECIM_RATIO_BIT0,
                           CURRENT_BOOST_STRAP, PGA_AMP_SEL_BIT1, PGA_AMP_SEL_BIT0};
            pin_sync_q <= pin_meta_q;
        end
    end
    logic sck_s, sel_s;
    assign sck_s = pin_sync_q[6];
    assign sel_s = pin_sync_q[5];

    ////////////////////////////////////////////////////////////////////////////
    // internal reset: watchdog only; PART_RESET_N stays high during external reset
    logic wd_fire;
    logic wd_rst_q;
    logic rel_q;
    logic mode_q;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            wd_rst_q <= 1'b0;
        end else begin
            wd_rst_q <= wd_fire;
        end
    end
    assign PART_RESET_N = !wd_rst_q;

    // mode caught once the select synchroniser holds the pin, after any reset ends
    // (the synchroniser itself is cleared by the external reset, so wait it out)
    logic [1:0] rel_cnt_q;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            rel_cnt_q <= 2'h0;
            rel_q <= 1'b0;
            mode_q <= 1'b0;
        end else if (wd_rst_q) begin
            rel_cnt_q <= 2'h0;
            rel_q <= 1'b0;
            mode_q <= 1'b0;
        end else if (!rel_q) begin
            if (rel_cnt_q == 2'h2) begin
                rel_q <= 1'b1;
                mode_q <= sel_s;
            end else begin
                rel_cnt_q <= rel_cnt_q + 2'h1;
            end
        end
    end
    assign TWO_WIRE_MODE = mode_q;

    twf_watchdog #(
        .TIMEOUT(WATCH_TIMEOUT)
    ) u_watchdog (
        .clk(CLK),
        .resetn(RESETN),
        .enable(mode_q),
        .sck_level(sck_s),
        .expired(wd_fire)
    );

    ////////////////////////////////////////////////////////////////////////////
    // strap capture on select rising edge
    logic [4:0] strap_q;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            sel_prev_q <= 1'b0;
            strap_q <= 5'h00;
        end else if (wd_rst_q) begin
            sel_prev_q <= 1'b0;
            strap_q <= 5'h00;
        end else begin
            sel_prev_q <= sel_s;
            if (sel_s && !sel_prev_q) begin
                strap_q <= pin_sync_q[4:0];
            end
        end
    end

    // decoded settings; everything else stays at defaults
    always_comb begin
        case (strap_q[4:3])
            2'b00: OSR_SETTING = OSR_64;
            2'b01: OSR_SETTING = OSR_128;
            2'b10: OSR_SETTING = OSR_256;
            default: OSR_SETTING = OSR_512;
        endcase
        BIAS_SETTING = strap_q[2] ? BIAS_FULL : BIAS_HALF;
        case (strap_q[1:0])
            2'b00: CH0_GAIN_SETTING = GAIN_1;
            2'b01: CH0_GAIN_SETTING = GAIN_8;
            2'b10: CH0_GAIN_SETTING = GAIN_16;
            default: CH0_GAIN_SETTING = GAIN_32;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // result hand-off: settle count, word capture, toggle to link side
    logic [3:0] settle_q;
    logic [23:0] word_q;
    logic [4:0] cfg_q;
    logic req_tgl_q;
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            settle_q <= 4'h0;
            word_q <= 24'h000000;
            cfg_q <= 5'h00;
            req_tgl_q <= 1'b0;
        end else if (wd_rst_q || !mode_q) begin
            settle_q <= 4'h0;
        end else if (RESULT_VALID) begin
            if (settle_q < 4'(SETTLE)) begin
                settle_q <= settle_q + 4'h1;
            end else begin
                word_q <= CONVERSION_RESULT_WORD;
                cfg_q <= strap_q;
                req_tgl_q <= !req_tgl_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link domain on the serial clock
    logic [2:0] lk_tgl_q;
    logic lk_rst_meta_q, lk_rst_q;
    always_ff @(posedge SCK or negedge RESETN) begin
        if (!RESETN) begin
            lk_rst_meta_q <= 1'b0;
            lk_rst_q <= 1'b0;
        end else begin
            lk_rst_meta_q <= mode_q && PART_RESET_N;
            lk_rst_q <= lk_rst_meta_q;
        end
    end
    always_ff @(posedge SCK or negedge RESETN) begin
        if (!RESETN) begin
            lk_tgl_q <= 3'h0;
        end else begin
            lk_tgl_q <= {lk_tgl_q[1:0], req_tgl_q};
        end
    end
    logic lk_new;
    assign lk_new = lk_tgl_q[2] ^ lk_tgl_q[1];

    twf_state_type state_q;
    logic [55:0] shift_q;
    logic [5:0] bit_q;
    logic [1:0] idx_q;
    logic [15:0] sync_w;
    logic [39:0] body_w;
    logic [15:0] crc_w;
    logic long_w;
    assign long_w = cfg_q[4:3] != 2'b00;

    // sync word of the current frame
    always_comb begin
        sync_w = 16'h0000;
        sync_w[15:8] = SYNC_CONST;
        sync_w[SYNC_IDX_POS +: 2] = idx_q;
        sync_w[SYNC_RATIO_POS +: 2] = cfg_q[4:3];
        sync_w[SYNC_BOOST_POS] = cfg_q[2];
        sync_w[SYNC_GAIN_POS +: 2] = cfg_q[1:0];
        body_w = long_w ? {sync_w, word_q} : {8'h00, sync_w, word_q[23:8]};
    end

    // bitwise crc, msb first, over sync and result
    always_comb begin
        crc_w = CRC_INIT;
        for (int i = 39; i >= 0; i--) begin
            if (long_w || i < 32) begin
                crc_w = {crc_w[14:0], 1'b0} ^ ((crc_w[15] ^ body_w[i]) ? CRC_POLY : 16'h0000);
            end
        end
    end

    // frame engine: four frames per result, then low
    always_ff @(posedge SCK or negedge RESETN) begin
        if (!RESETN) begin
            state_q <= TWF_IDLE;
            shift_q <= 56'h0;
            bit_q <= 6'h00;
            idx_q <= 2'b00;
        end else if (!lk_rst_q) begin
            state_q <= TWF_IDLE;
            shift_q <= 56'h0;
            bit_q <= 6'h00;
            idx_q <= 2'b00;
        end else begin
            case (state_q)
                TWF_IDLE: begin
                    if (lk_new) begin
                        state_q <= TWF_GAP;
                        idx_q <= 2'b00;
                    end
                end
                TWF_GAP: begin
                    // load the frame: sync, result, crc
                    shift_q <= long_w ? {body_w, crc_w} : {body_w[31:0], crc_w, 8'h00};
                    bit_q <= long_w ? 6'(FRAME_LONG_BITS - 1) : 6'(FRAME_SHORT_BITS - 1);
                    state_q <= TWF_SEND;
                end
                TWF_SEND: begin
                    shift_q <= {shift_q[54:0], 1'b0};
                    if (bit_q == 6'h00) begin
                        if (idx_q == 2'(FRAMES_PER_SET - 1)) begin
                            state_q <= TWF_IDLE;
                        end else begin
                            idx_q <= idx_q + 2'b01;
                            state_q <= TWF_GAP;
                        end
                    end else begin
                        bit_q <= bit_q - 6'h01;
                    end
                end
                default: state_q <= TWF_IDLE;
            endcase
        end
    end

    // output register: low unless shifting
    logic sdo_q;
    always_ff @(posedge SCK or negedge RESETN) begin
        if (!RESETN) begin
            sdo_q <= 1'b0;
        end else begin
            sdo_q <= lk_rst_q && (state_q == TWF_SEND) && shift_q[55];
        end
    end
    assign SDO = sdo_q;
    assign SDO_OE = 1'b1;

    AST_IDLE_LOW: assert property (@(posedge SCK) disable iff (!RESETN)
        (state_q == TWF_IDLE) |=> !SDO) else $error("data pin high while idle");
    AST_FOURTH_ENDS: assert property (@(posedge SCK) disable iff (!RESETN || !lk_rst_q)
        (state_q == TWF_SEND && bit_q == 6'h00 && idx_q == 2'b11) |=> state_q == TWF_IDLE)
        else $error("set did not end after fourth frame");
    AST_SETTLE: assert property (@(posedge CLK) disable iff (!RESETN)
        (RESULT_VALID && settle_q < 4'(SETTLE)) |=> $stable(req_tgl_q))
        else $error("frame requested before settling");
    AST_STRAP_HOLD: assert property (@(posedge CLK) disable iff (!RESETN || wd_rst_q)
        !(sel_s && !sel_prev_q) |=> $stable(strap_q)) else $error("straps changed off edge");
    AST_MODE_HOLD: assert property (@(posedge CLK) disable iff (!RESETN || wd_rst_q)
        rel_q |=> $stable(mode_q)) else $error("mode changed outside reset");
    // watchdog reset steps: reset pulse, then the mode latch reopens
    sequence wd_reset_seq;
        !PART_RESET_N ##1 !rel_q;
    endsequence
    AST_WD_RESET: assert property (@(posedge CLK) disable iff (!RESETN)
        wd_fire |=> wd_reset_seq) else $error("watchdog did not reset");
    AST_PART_RESET_ONE: assert property (@(posedge CLK) disable iff (!RESETN)
        !PART_RESET_N |=> PART_RESET_N) else $error("part reset longer than one cycle");
    AST_MODE_LATCH: assert property (@(posedge CLK) disable iff (!RESETN || wd_rst_q)
        (!rel_q && rel_cnt_q == 2'h2) |=> (rel_q && mode_q == $past(sel_s)))
        else $error("mode not taken from select");
    AST_SPI_NO_FRAMES: assert property (@(posedge CLK) disable iff (!RESETN)
        (rel_q && !mode_q) |=> $stable(req_tgl_q)) else $error("frames in spi mode");
    AST_OSR_DECODE: assert property (@(posedge CLK) disable iff (!RESETN)
        strap_q[4:3] == 2'b00 |-> OSR_SETTING == OSR_64) else $error("ratio decode wrong");
    AST_GAIN_DECODE: assert property (@(posedge CLK) disable iff (!RESETN)
        strap_q[1:0] == 2'b11 |-> CH0_GAIN_SETTING == GAIN_32) else $error("gain decode wrong");
    AST_GAIN_UNITY: assert property (@(posedge CLK) disable iff (!RESETN)
        strap_q[1:0] == 2'b00 |-> CH0_GAIN_SETTING == GAIN_1) else $error("unity gain decode wrong");
    AST_OSR_TOP: assert property (@(posedge CLK) disable iff (!RESETN)
        strap_q[4:3] == 2'b11 |-> OSR_SETTING == OSR_512) else $error("top ratio decode wrong");
    AST_BIAS_DECODE: assert property (@(posedge CLK) disable iff (!RESETN)
        strap_q[2] |-> BIAS_SETTING == BIAS_FULL) else $error("bias decode wrong");

    ////////////////////////////////////////////////////////////////////////////
    // link-side checks
    AST_GAP_LOW: assert property (@(posedge SCK) disable iff (!RESETN)
        (state_q == TWF_GAP) |=> !SDO) else $error("data pin high in frame gap");
    AST_SET_START: assert property (@(posedge SCK) disable iff (!RESETN || !lk_rst_q)
        (state_q == TWF_IDLE && lk_new) |=> (state_q == TWF_GAP && idx_q == 2'b00))
        else $error("set did not start at frame zero");
    AST_LINK_HELD: assert property (@(posedge SCK) disable iff (!RESETN)
        !lk_rst_q |=> state_q == TWF_IDLE) else $error("frame engine ran while held");
endmodule

// *** testbench/twf_host_model.sv ***
`timescale 1ns/1ps
// host side: drives the shared serial clock and collects frames from the data line
module twf_host_model (
    input wire logic run_sck,
    input wire logic hold_high,
    input wire logic long_frame,
    input wire logic sdo,
    output logic sck,
    output logic [55:0] frame,
    output int nframes
);
    logic [55:0] sh;
    int cnt;
    initial begin
        sck = 1'b0;
        frame = 56'h0;
        nframes = 0;
        cnt = 0;
    end
    ////////////////////////////////////////////////////////////////////////
    // free-running clock, 32 ns high phase, held high only on command
    always #32 sck <= hold_high | (run_sck & ~sck);
    ////////////////////////////////////////////////////////////////////////
    // frame starts at first high bit (sync msb); sample on falling edge
    always @(negedge sck) begin
        if (cnt == 0 && sdo === 1'b1) begin
            sh = 56'h1;
            cnt = 1;
        end else if (cnt != 0) begin
            sh = {sh[54:0], sdo};
            cnt++;
            if (cnt == (long_frame ? 56 : 48)) begin
                frame = sh;
                nframes++;
                cnt = 0;
            end
        end
    end
endmodule

// *** testbench/twf_framer_tb_top.sv ***
`timescale 1ns/1ps
module twf_framer_tb_top;
    import twf_pkg::*;
    localparam logic [5:0] GT [4] = '{GAIN_1, GAIN_8, GAIN_16, GAIN_32};
    logic clk = 1'b0, resetn = 1'b0, sel = 1'b1, rvalid = 1'b0;
    logic run_sck = 1'b1, hold_high = 1'b0, long_frame = 1'b0, wd_seen = 1'b0;
    logic [4:0] st = 5'h00; // ratio1 ratio0 boost pga_amp_sel_bit1 pga_amp_sel_bit0
    logic [23:0] result = 24'h000000;
    logic sdo, sdo_oe, two_wire, bias, part_rst_n, sck;
    logic [9:0] osr;
    logic [5:0] gain;
    logic [55:0] frame;
    int nframes, n_mismatch = 0, checked = 0, cycles = 0;
    twf_framer #(.WATCH_TIMEOUT(8), .SETTLE(1)) twf_framer_inst (.CLK(clk), .RESETN(resetn), .SCK(sck),
        .INTERFACE_SELECT_PIN(sel), .DECIM_RATIO_BIT0(st[3]), .DECIM_RATIO_BIT1(st[4]),
        .CURRENT_BOOST_STRAP(st[2]), .PGA_AMP_SEL_BIT0(st[0]), .PGA_AMP_SEL_BIT1(st[1]),
        .CONVERSION_RESULT_WORD(result), .RESULT_VALID(rvalid), .SDO(sdo), .SDO_OE(sdo_oe),
        .TWO_WIRE_MODE(two_wire), .OSR_SETTING(osr), .BIAS_SETTING(bias), .CH0_GAIN_SETTING(gain),
        .PART_RESET_N(part_rst_n));
    twf_host_model twf_host_model_inst (.run_sck(run_sck), .hold_high(hold_high), .long_frame(long_frame),
        .sdo(sdo), .sck(sck), .frame(frame), .nframes(nframes));
    ////////////////////////////////////////////////////////////////////////
    // main clock, watchdog pulse catcher, hang limit
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (part_rst_n === 1'b0) wd_seen <= 1'b1;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_mismatch++;
            close_out();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic chk(string what, logic [55:0] seen, logic [55:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic clks(int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic load(logic [4:0] s);
        sel <= 1'b0;
        clks(4);
        st <= s;
        clks(4);
        sel <= 1'b1;
        clks(6);
    endtask
    task automatic pulse(logic [23:0] r);
        result <= r;
        rvalid <= 1'b1;
        @(posedge clk);
        rvalid <= 1'b0;
    endtask
    task automatic wait_n(int n);
        int k;
        k = 0;
        while (nframes < n && k < 400) begin
            @(posedge clk);
            k++;
        end
    endtask
    function automatic logic [55:0] exp_frame(logic [4:0] s, logic [1:0] i, logic [23:0] r);
        logic [15:0] sy;
        logic [39:0] m;
        logic [15:0] c;
        int n;
        sy = {SYNC_CONST, i, s, 1'b0};
        n = (s[4:3] == 2'b00) ? 32 : 40;
        m = (n == 32) ? {8'h00, sy, r[23:8]} : {sy, r};
        c = CRC_INIT;
        for (int k = n - 1; k >= 0; k--) c = (c[15] ^ m[k]) ? ((c << 1) ^ CRC_POLY) : (c << 1);
        return (n == 32) ? {8'h00, m[31:0], c} : {m, c};
    endfunction
    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_straps();
        logic [4:0] s;
        for (int c = 0; c < 4; c++) begin
            s = {c[1:0], c[0], c[1:0] ^ 2'b01};
            load(s);
            chk("osr", osr, 10'h040 << c);
            chk("bias", bias, s[2]);
            chk("gain", gain, GT[s[1:0]]);
            chk("mode", two_wire, 1'b1);
        end
        st <= 5'h00;
        clks(8);
        chk("osr held", osr, OSR_512);
        $display("test straps done");
    endtask
    task automatic t_settle();
        load(5'b00110);
        pulse(24'h123456);
        clks(300);
        chk("frames before settle", nframes, 0);
        $display("test settle done");
    endtask
    task automatic t_frames(logic [4:0] s, logic [23:0] r);
        int base;
        load(s);
        long_frame <= (s[4:3] != 2'b00);
        base = nframes;
        pulse(r);
        for (int i = 0; i < 4; i++) begin
            wait_n(base + i + 1);
            chk("frame", frame, exp_frame(s, i[1:0], r));
        end
        clks(100);
        chk("frames after set", nframes, base + 4);
        chk("sdo idle", sdo, 1'b0);
        chk("sdo drive", sdo_oe, 1'b1);
        $display("test frames done");
    endtask
    task automatic t_watchdog();
        run_sck <= 1'b0;
        clks(60);
        chk("no reset on low", wd_seen, 1'b0);
        sel <= 1'b0;
        hold_high <= 1'b1;
        clks(30);
        hold_high <= 1'b0;
        run_sck <= 1'b1;
        clks(10);
        chk("watchdog reset", wd_seen, 1'b1);
        chk("mode after", two_wire, 1'b0);
        chk("osr default", osr, OSR_64);
        $display("test watchdog done");
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        clks(10);
        resetn <= 1'b1;
        clks(4);
        t_straps();
        t_settle();
        t_frames(5'b00110, 24'hc3a5f0);
        t_frames(5'b10011, 24'h89abcd);
        t_watchdog();
        close_out();
    end
endmodule
